// [rtl/fetx_encoder.sv]
// 100 Mb/s transmit path: 4b/5b, scrambler, nrzi and three-level split
// Functional notes
// - each nibble becomes a five-bit code-group
// - fixed data nibble to code-group table
// - halt, idle, start and end control codes
// - invalid patterns and misplaced controls flagged
// - start pair replaces first two preamble nibbles
// - end pair follows last data on enable drop
// - idle sent continuously until next frame
// - stream xored with free-running eleven-bit lfsr
// - lfsr seed taken from address strap
// - scrambler can be bypassed
// - scrambled stream converted to nrzi
// - two streams with alternating one events
// - only three-level output, no binary mode
// - five line bits per nibble, 125 Mb/s
// - standard 100BASE-TX transmit sequencing
`timescale 1ns/1ps
`default_nettype none
module fetx_encoder
    import fetx_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        txEn,
    input  wire logic                        txEr,
    input  wire logic [fetx_pkg::NIB_W-1:0]   txd,
    output logic                             macReady,
    input  wire logic [fetx_pkg::STRAP_W-1:0] phyAddressStrap,
    input  wire logic                        scrambleBypass,
    output logic      [fetx_pkg::SYM_W-1:0]   linePos,
    output logic      [fetx_pkg::SYM_W-1:0]   lineNeg,
    output logic                             codeFault
);
    // pin synchronisers
    logic [STRAP_W-1:0] strapMetaFf;
    logic [STRAP_W-1:0] strapSyncFf;
    logic               bypassMetaFf;
    logic               bypassSyncFf;

    always_ff @(posedge clk) begin
        strapMetaFf  <= phyAddressStrap;
        strapSyncFf  <= strapMetaFf;
        bypassMetaFf <= scrambleBypass;
        bypassSyncFf <= bypassMetaFf;
    end

    // mac side: push nibbles, then one end marker when enable drops
    logic             txEnDlyFf;
    logic             nxt_txEnDly;
    logic             pushValid;
    logic [ENT_W-1:0] pushData;

    always_comb begin
        nxt_txEnDly = txEn;
        pushValid   = txEn || txEnDlyFf;
        pushData    = txEn ? {1'b0, txEr, txd} : {1'b1, 1'b0, NIB_W'(0)};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            txEnDlyFf <= 1'b0;
        end else begin
            txEnDlyFf <= nxt_txEnDly;
        end
    end

    logic             popValid;
    logic             popReady;
    logic [ENT_W-1:0] popData;
    logic             popEnd;
    logic             popErr;
    logic [NIB_W-1:0] popNib;

    fetx_fifo #(
        .WIDTH (ENT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (pushValid),
        .inReady  (macReady),
        .inData   (pushData),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popData)
    );

    assign popEnd = popData[ENT_END_BIT];
    assign popErr = popData[ENT_ERR_BIT];
    assign popNib = popData[NIB_W-1:0];

    // code-group sequencer: one code-group per clock
    fetx_state_e      stateFf;
    fetx_state_e      nxt_state;
    logic [SYM_W-1:0] symFf;
    logic [SYM_W-1:0] nxt_sym;
    logic             dataFieldFf;
    logic             nxt_dataField;
    logic             codeFaultFf;
    logic             nxt_codeFault;

    always_comb begin
        nxt_state     = stateFf;
        nxt_sym       = SYM_I;
        popReady      = 1'b0;
        nxt_dataField = 1'b0;
        unique case (stateFf)
            ST_IDLE: begin
                if (popValid) begin
                    popReady = 1'b1;
                    if (!popEnd) begin
                        nxt_sym   = SYM_J;
                        nxt_state = ST_K;
                    end
                end
            end
            ST_K: begin
                nxt_sym   = SYM_K;
                popReady  = popValid;
                nxt_state = ST_DATA;
            end
            ST_DATA: begin
                popReady = popValid;
                if (popValid && popEnd) begin
                    nxt_sym   = SYM_T;
                    nxt_state = ST_R;
                end else if (popValid && !popErr) begin
                    nxt_sym       = fetx_encode(popNib);
                    nxt_dataField = 1'b1;
                end else begin
                    nxt_sym       = SYM_H;
                    nxt_dataField = 1'b1;
                end
            end
            ST_R: begin
                nxt_sym   = SYM_R;
                nxt_state = ST_IDLE;
            end
        endcase
        // self check of the data field contents
        nxt_codeFault = dataFieldFf && (fetx_is_invalid(symFf) ||
                        (!fetx_is_data(symFf) && symFf != SYM_H));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stateFf     <= ST_IDLE;
            symFf       <= SYM_RESET;
            dataFieldFf <= 1'b0;
            codeFaultFf <= 1'b0;
        end else begin
            stateFf     <= nxt_state;
            symFf       <= nxt_sym;
            dataFieldFf <= nxt_dataField;
            codeFaultFf <= nxt_codeFault;
        end
    end

    assign codeFault = codeFaultFf;

    // scrambler, seeded from the address strap
    logic [LFSR_W-1:0] seed;
    logic [SYM_W-1:0]  scrSym;

    assign seed = {SEED_HI, strapSyncFf};

    fetx_scrambler u_scrambler (
        .clk    (clk),
        .rst    (rst),
        .seed   (seed),
        .bypass (bypassSyncFf),
        .symIn  (symFf),
        .symOut (scrSym)
    );

    // nrzi and three-level split, bit 4 leaves first
    logic [SYM_W-1:0] nrziFf;
    logic [SYM_W-1:0] nxt_nrzi;
    logic [1:0]       mltPhaseFf;
    logic [1:0]       nxt_mltPhase;
    logic [SYM_W-1:0] linePosFf;
    logic [SYM_W-1:0] lineNegFf;
    logic [SYM_W-1:0] nxt_linePos;
    logic [SYM_W-1:0] nxt_lineNeg;
    logic             level;
    logic             prevLevel;

    always_comb begin
        level        = nrziFf[0];
        prevLevel    = nrziFf[0];
        nxt_mltPhase = mltPhaseFf;
        nxt_nrzi     = '0;
        nxt_linePos  = '0;
        nxt_lineNeg  = '0;
        for (int i = BITS_PER_CLK - 1; i >= 0; i--) begin
            level       = level ^ scrSym[i];
            nxt_nrzi[i] = level;
            if (level != prevLevel) begin
                nxt_mltPhase = nxt_mltPhase + 2'h1;
            end
            prevLevel      = level;
            nxt_linePos[i] = (nxt_mltPhase == MLT_PLUS);
            nxt_lineNeg[i] = (nxt_mltPhase == MLT_MINUS);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nrziFf     <= {SYM_W{NRZI_RESET}};
            mltPhaseFf <= MLT_RESET;
            linePosFf  <= '0;
            lineNegFf  <= '0;
        end else begin
            nrziFf     <= nxt_nrzi;
            mltPhaseFf <= nxt_mltPhase;
            linePosFf  <= nxt_linePos;
            lineNegFf  <= nxt_lineNeg;
        end
    end

    // only the two three-level halves leave the block
    assign linePos = linePosFf;
    assign lineNeg = lineNegFf;

    encode_map_a: assert property (@(posedge clk) disable iff (rst)
        (stateFf == ST_DATA && popValid && !popEnd && !popErr)
        |=> symFf == fetx_encode($past(popNib)))
        else $error("data nibble mapped to wrong code-group");
    halt_on_err_a: assert property (@(posedge clk) disable iff (rst)
        (stateFf == ST_DATA && popValid && !popEnd && popErr) |=> symFf == SYM_H)
        else $error("mac error did not send halt");
    idle_fill_a: assert property (@(posedge clk) disable iff (rst)
        (stateFf == ST_IDLE && !popValid) |=> symFf == SYM_I)
        else $error("idle not sent between frames");
    start_pair_a: assert property (@(posedge clk) disable iff (rst)
        (stateFf == ST_IDLE && popValid && !popEnd) |=> symFf == SYM_J ##1 symFf == SYM_K)
        else $error("frame did not open with the start pair");
    end_pair_a: assert property (@(posedge clk) disable iff (rst)
        (stateFf == ST_DATA && popValid && popEnd)
        |=> symFf == SYM_T ##1 (symFf == SYM_R && stateFf == ST_IDLE))
        else $error("frame did not close with the end pair");
    code_fault_a: assert property (@(posedge clk) disable iff (rst) !codeFaultFf)
        else $error("control or invalid code-group inside data field");
    nrzi_toggle_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> nrziFf[0] == ($past(nrziFf[0]) ^ (^$past(scrSym))))
        else $error("nrzi level does not follow the one bits");
    mlt_exclusive_a: assert property (@(posedge clk) disable iff (rst)
        (linePosFf & lineNegFf) == '0)
        else $error("both three-level halves driven together");
    mlt_step_a: assert property (@(posedge clk) disable iff (rst)
        $past(scrSym) == '0 |-> mltPhaseFf == $past(mltPhaseFf))
        else $error("three-level phase moved without a transition");
    k_follows_j_a: assert property (@(posedge clk) disable iff (rst)
        stateFf == ST_K |=> symFf == SYM_K && stateFf == ST_DATA)
        else $error("second start code-group missing");
    data_field_a: assert property (@(posedge clk) disable iff (rst)
        (stateFf == ST_DATA && popValid && !popEnd) |=> dataFieldFf)
        else $error("data code-group not marked as data field");

endmodule
`default_nettype wire

// [rtl/fetx_pkg.sv]
// shared constants, types and code-group helpers of the transmit encoder
package fetx_pkg;

    // line timing: 25 MHz symbol clock, 125 Mb/s serial stream
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned BIT_TIME_NS   = 8;
    localparam int unsigned BITS_PER_CLK  = CLK_PERIOD_NS / BIT_TIME_NS;

    // widths and depths
    localparam int unsigned SYM_W      = 5;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned STRAP_W    = 5;
    localparam int unsigned LFSR_W     = 11;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned ENT_W      = 6;

    // fifo entry layout: end marker, error flag, nibble
    localparam int unsigned ENT_END_BIT = 5;
    localparam int unsigned ENT_ERR_BIT = 4;

    // scrambler taps for x^11 + x^9 + 1 and fixed upper seed bits
    localparam int unsigned TAP_A   = 10;
    localparam int unsigned TAP_B   = 8;
    localparam logic [5:0]  SEED_HI = 6'h2B;

    // control code-groups
    localparam logic [4:0] SYM_H = 5'h04;
    localparam logic [4:0] SYM_I = 5'h1F;
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;

    // reset values
    localparam logic [4:0] SYM_RESET  = SYM_I;
    localparam logic [1:0] MLT_RESET  = 2'h0;
    localparam logic       NRZI_RESET = 1'b0;

    // three-level phases: zero, plus, zero, minus
    localparam logic [1:0] MLT_PLUS  = 2'h1;
    localparam logic [1:0] MLT_MINUS = 2'h3;

    typedef enum logic [1:0] {ST_IDLE, ST_K, ST_DATA, ST_R} fetx_state_e;

    function automatic logic [4:0] fetx_encode(input logic [3:0] nib);
        logic [4:0] sym;
        unique case (nib)
            4'h0: sym = 5'h1E;
            4'h1: sym = 5'h09;
            4'h2: sym = 5'h14;
            4'h3: sym = 5'h15;
            4'h4: sym = 5'h0A;
            4'h5: sym = 5'h0B;
            4'h6: sym = 5'h0E;
            4'h7: sym = 5'h0F;
            4'h8: sym = 5'h12;
            4'h9: sym = 5'h13;
            4'hA: sym = 5'h16;
            4'hB: sym = 5'h17;
            4'hC: sym = 5'h1A;
            4'hD: sym = 5'h1B;
            4'hE: sym = 5'h1C;
            4'hF: sym = 5'h1D;
        endcase
        return sym;
    endfunction

    function automatic logic fetx_is_invalid(input logic [4:0] sym);
        logic bad;
        bad = (sym == 5'h00) || (sym == 5'h01) || (sym == 5'h02) || (sym == 5'h03) ||
              (sym == 5'h05) || (sym == 5'h06) || (sym == 5'h08) || (sym == 5'h0C);
        return bad;
    endfunction

    function automatic logic fetx_is_data(input logic [4:0] sym);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (fetx_encode(4'(i)) == sym) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

endpackage

// [rtl/fetx_fifo.sv]
// nibble fifo between the mac input and the code-group encoder
`timescale 1ns/1ps
`default_nettype none
module fetx_fifo #(
    parameter int unsigned WIDTH = 6,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] memFf [DEPTH];
    logic [PW-1:0]    wrPtrFf;
    logic [PW-1:0]    rdPtrFf;
    logic [PW:0]      countFf;
    logic [PW-1:0]    nxt_wrPtr;
    logic [PW-1:0]    nxt_rdPtr;
    logic [PW:0]      nxt_count;
    logic             doWr;
    logic             doRd;

    always_comb begin
        inReady   = (countFf != (PW+1)'(DEPTH));
        outValid  = (countFf != '0);
        outData   = memFf[rdPtrFf];
        doWr      = inValid && inReady;
        doRd      = outValid && outReady;
        nxt_wrPtr = doWr ? ((wrPtrFf == PW'(DEPTH - 1)) ? '0 : wrPtrFf + 1'b1) : wrPtrFf;
        nxt_rdPtr = doRd ? ((rdPtrFf == PW'(DEPTH - 1)) ? '0 : rdPtrFf + 1'b1) : rdPtrFf;
        nxt_count = countFf + (PW+1)'(doWr) - (PW+1)'(doRd);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtrFf <= '0;
            rdPtrFf <= '0;
            countFf <= '0;
        end else begin
            wrPtrFf <= nxt_wrPtr;
            rdPtrFf <= nxt_rdPtr;
            countFf <= nxt_count;
        end
        if (doWr) begin
            memFf[wrPtrFf] <= inData;
        end
    end

endmodule
`default_nettype wire

// [rtl/fetx_scrambler.sv]
// eleven-bit lfsr scrambler with bypass, five bits per clock
`timescale 1ns/1ps
`default_nettype none
module fetx_scrambler
    import fetx_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [fetx_pkg::LFSR_W-1:0] seed,
    input  wire logic                       bypass,
    input  wire logic [fetx_pkg::SYM_W-1:0]  symIn,
    output logic      [fetx_pkg::SYM_W-1:0]  symOut
);
    logic [LFSR_W-1:0] lfsrFf;
    logic [LFSR_W-1:0] nxt_lfsr;
    logic [SYM_W-1:0]  keyBits;
    logic [SYM_W-1:0]  nxt_symOut;

    always_comb begin
        nxt_lfsr = lfsrFf;
        keyBits  = '0;
        for (int i = SYM_W - 1; i >= 0; i--) begin
            keyBits[i] = nxt_lfsr[TAP_A] ^ nxt_lfsr[TAP_B];
            nxt_lfsr   = {nxt_lfsr[LFSR_W-2:0], keyBits[i]};
        end
        if (nxt_lfsr == '0) begin
            nxt_lfsr = seed;
        end
        nxt_symOut = bypass ? symIn : (symIn ^ keyBits);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lfsrFf <= seed;
            symOut <= SYM_RESET;
        end else begin
            lfsrFf <= nxt_lfsr;
            symOut <= nxt_symOut;
        end
    end

    seed_load_a: assert property (@(posedge clk) rst [*3] |=> lfsrFf == $past(seed))
        else $error("scrambler did not load the seed");
    lfsr_nonzero_a: assert property (@(posedge clk) disable iff (rst) lfsrFf != '0)
        else $error("scrambler reached the all-zero state");
    scramble_xor_a: assert property (@(posedge clk) disable iff (rst)
        !bypass |=> symOut == ($past(symIn) ^ $past(keyBits)))
        else $error("scrambled symbol is not data xor key");
    bypass_pass_a: assert property (@(posedge clk) disable iff (rst)
        bypass |=> symOut == $past(symIn))
        else $error("bypassed symbol was altered");

endmodule
`default_nettype wire

// [test/fetx_mac_model.sv]
// mac-side model that drives nibble frames into the encoder
`timescale 1ns/1ps
`default_nettype none
module fetx_mac_model (
    input  wire logic       clk,
    output logic            txEn,
    output logic            txEr,
    output logic [3:0]      txd
);
    logic       pend;
    logic [3:0] first;
    int         len;
    int         errAt;
    int         idx;

    initial begin
        txEn  = 1'b0;
        txEr  = 1'b0;
        txd   = 4'h0;
        pend  = 1'b0;
        first = 4'h0;
        len   = 0;
        errAt = -1;
        idx   = 0;
    end

    // preamble 5,5 then counting nibbles; between frames the lines wander
    always @(negedge clk) begin
        if (pend) begin
            txEn <= 1'b1;
            txEr <= (errAt >= 0) && (idx == errAt + 2);
            txd  <= (idx < 2) ? 4'h5 : 4'(first + idx - 2);
            idx  <= idx + 1;
            if (idx == len + 1) begin
                pend <= 1'b0;
            end
        end else begin
            txEn <= 1'b0;
            txEr <= 1'b0;
            txd  <= ~txd;
        end
    end

    task automatic send(input logic [3:0] f, input int n, input int e);
        @(posedge clk);
        first = f;
        len   = n;
        errAt = e;
        idx   = 0;
        pend  = 1'b1;
        wait (pend == 1'b0);
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// [test/fetx_encoder_test.sv]
// self-checking bench for the transmit line encoder
`timescale 1ns/1ps
`default_nettype none
module fetx_encoder_test;
    import fetx_pkg::*;
    localparam logic [4:0] CODE [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                         5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        scrambleBypass = 1'b1;
    logic [4:0]  phyAddressStrap = 5'h00;
    logic        txEn;
    logic        txEr;
    logic [3:0]  txd;
    logic        macReady;
    logic        codeFault;
    logic [4:0]  linePos;
    logic [4:0]  lineNeg;
    logic [1:0]  prevPair = 2'b00;
    logic [1:0]  lastNz = 2'b01;
    logic [10:0] hist = 11'h000;
    logic [4:0]  syms [$];
    logic        lineBad = 1'b0;
    logic        keyBad = 1'b0;
    logic        faultSeen = 1'b0;
    logic        readyLow = 1'b0;
    int          mode = 0;
    int          trained = 0;
    int          n_errors = 0;
    int          compares = 0;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    fetx_mac_model mac_u (.clk(clk), .txEn(txEn), .txEr(txEr), .txd(txd));

    fetx_encoder dut_u (
        .clk(clk), .rst(rst), .txEn(txEn), .txEr(txEr), .txd(txd), .macReady(macReady),
        .phyAddressStrap(phyAddressStrap), .scrambleBypass(scrambleBypass),
        .linePos(linePos), .lineNeg(lineNeg), .codeFault(codeFault)
    );

    // line decoder: pole change means a one, key removed per mode
    always @(negedge clk) begin
        logic [1:0] pr;
        logic       b;
        logic       k;
        logic [4:0] s;
        if (rst) begin
            prevPair = 2'b00;
            lastNz   = 2'b01;
        end else begin
            for (int i = 4; i >= 0; i--) begin
                pr = {linePos[i], lineNeg[i]};
                b  = (pr != prevPair);
                if (pr == 2'b11 || (pr != 2'b00 && prevPair == 2'b00 && pr == lastNz)) begin
                    lineBad = 1'b1;
                end
                if (pr != 2'b00) begin
                    lastNz = pr;
                end
                k = (mode == 0) ? 1'b0 : (mode == 1) ? ~b : (hist[10] ^ hist[8]);
                if (mode == 1 && trained >= 11 && k !== (hist[10] ^ hist[8])) begin
                    keyBad = 1'b1;
                end
                if (mode == 1) begin
                    trained++;
                end
                hist     = {hist[9:0], k};
                s        = {s[3:0], b ^ k};
                prevPair = pr;
            end
            syms.push_back(s);
            if (codeFault !== 1'b0) begin
                faultSeen = 1'b1;
            end
            if (macReady !== 1'b1) begin
                readyLow = 1'b1;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [4:0] strap);
        @(negedge clk);
        phyAddressStrap = strap;
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
    endtask

    // walks one frame in the decoded stream from position p
    task automatic check_frame(input logic [3:0] f, input int n, input int e, input int nIdle, inout int p);
        while (p < syms.size() && syms[p] === SYM_I) begin
            p++;
        end
        check(syms.size() > p + n + 3 + nIdle, 1);
        if (syms.size() > p + n + 3 + nIdle) begin
            check(syms[p], SYM_J);
            check(syms[p + 1], SYM_K);
            for (int i = 0; i < n; i++) begin
                check(syms[p + 2 + i], (i == e) ? SYM_H : CODE[4'(f + i)]);
            end
            check(syms[p + n + 2], SYM_T);
            check(syms[p + n + 3], SYM_R);
            for (int i = 0; i < nIdle; i++) begin
                check(syms[p + n + 4 + i], SYM_I);
            end
            p = p + n + 4;
        end
        check({lineBad, faultSeen, readyLow}, 3'b000);
    endtask

    task automatic frame_case(input logic [3:0] f, input int n, input int e);
        int p;
        p = 0;
        @(posedge clk);
        syms.delete();
        mac_u.send(f, n, e);
        repeat (14) @(posedge clk);
        check_frame(f, n, e, 4, p);
    endtask

    task automatic t_all_codes();
        frame_case(4'h0, 16, -1);
        $display("test all_codes done");
    endtask

    task automatic t_halt_in_data();
        frame_case(4'h7, 6, 2);
        $display("test halt_in_data done");
    endtask

    task automatic t_back_to_back();
        int p;
        p = 0;
        @(posedge clk);
        syms.delete();
        mac_u.send(4'hC, 3, -1);
        mac_u.send(4'h3, 1, -1);
        repeat (16) @(posedge clk);
        check_frame(4'hC, 3, -1, 0, p);
        check_frame(4'h3, 1, -1, 3, p);
        $display("test back_to_back done");
    endtask

    task automatic t_scrambled();
        @(negedge clk);
        scrambleBypass = 1'b0;
        repeat (10) @(posedge clk);
        trained = 0;
        mode = 1;
        repeat (6) @(posedge clk);
        check(keyBad, 1'b0);
        check(hist != 11'h000, 1'b1);
        mode = 2;
        frame_case(4'hA, 5, -1);
        $display("test scrambled done");
    endtask

    task automatic t_strap_seed();
        logic [10:0] capA;
        do_reset(5'h00);
        repeat (6) @(posedge clk);
        trained = 0;
        mode = 1;
        repeat (4) @(posedge clk);
        capA = hist;
        mode = 0;
        do_reset(5'h1F);
        repeat (6) @(posedge clk);
        trained = 0;
        mode = 1;
        repeat (4) @(posedge clk);
        check(capA !== hist, 1'b1);
        check(keyBad, 1'b0);
        $display("test strap_seed done");
    endtask

    initial begin
        #(CLK_PERIOD_NS * 5000);
        n_errors++;
        print_verdict();
    end

    initial begin
        do_reset(5'h0A);
        repeat (4) @(posedge clk);
        t_all_codes();
        t_halt_in_data();
        t_back_to_back();
        t_scrambled();
        t_strap_seed();
        print_verdict();
    end
endmodule
`default_nettype wire
